// ---- core/ctl_space_pkg.sv ----
`default_nettype none
package ctl_space_pkg;

   // geometry of the module and its control space
   localparam int unsigned SUBPOS_N = 4;
   localparam int unsigned SUB_W = 2;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned GROUP_LSB = 8;
   localparam int unsigned DWORD_LSB = 3;
   localparam int unsigned STRING_BYTES = 32;
   localparam int unsigned STRING_IDX_W = 5;
   localparam int unsigned PHYS_W = 36;

   // byte offsets of the register groups within the module's control space
   localparam logic [11:0] OFS_PARITY_STATUS = 12'h000;
   localparam logic [11:0] OFS_SELECTIVE_RESET = 12'h100;
   localparam logic [11:0] OFS_IDENTITY_STRING = 12'h200;
   localparam logic [11:0] OFS_CHANGE_STRING = 12'h300;
   localparam logic [11:0] OFS_INTERPROC_IRQ = 12'h400;
   localparam logic [11:0] OFS_DEBUG_MAILBOX = 12'h500;
   localparam logic [11:0] OFS_MODULE_PRESENCE = 12'h600;
   localparam logic [11:0] OFS_BUS_ERROR = 12'h700;

   // field positions
   localparam int unsigned GLOBAL_PARITY_FLAG_BIT = 0;
   localparam int unsigned LOCAL_PARITY_FLAG_BIT = 1;
   localparam int unsigned SELECTIVE_CPU_RESET_BIT = 0;
   localparam int unsigned GLOBAL_PARITY_IRQ_BIT = 0;
   localparam int unsigned LOCAL_PARITY_IRQ_BIT = 1;
   localparam int unsigned DEBUG_REQUEST_IRQ_BIT = 2;
   localparam int unsigned VEC_NMI_BIT = 6;
   localparam int unsigned VEC_GENERAL_HI = 5;
   localparam int unsigned VEC_GENERAL_LO = 2;
   localparam int unsigned VEC_TIMER_BIT = 1;
   localparam int unsigned VEC_ERROR_BIT = 0;
   localparam int unsigned PERIPH_LO = 16;
   localparam int unsigned PERIPH_W = 16;
   localparam int unsigned LED_FIRST_BIT = 6;
   localparam int unsigned LED_SECOND_BIT = 7;
   localparam int unsigned POSITION_FIELD_W = 4;
   localparam logic [3:0] POSITION_EMPTY = 4'hF;

   // writable bits of the interprocessor interrupt register
   localparam logic [31:0] IRQ_WRITE_MASK = 32'hFFFF_007C;

   // reset values
   localparam logic [1:0] PARITY_STATUS_RST = 2'h0;
   localparam logic SELECTIVE_RESET_RST = 1'b1;
   localparam logic [2:0] BUS_ERROR_RST = 3'h0;
   localparam logic [31:0] INTERPROC_IRQ_RST = 32'h0000_0000;
   localparam logic [15:0] DEBUG_MAILBOX_RST = 16'h0000;

   // boot flash window in the physical space
   localparam logic [PHYS_W-1:0] BOOT_RANGE_LO = 36'h0_1FC0_0000;
   localparam logic [PHYS_W-1:0] BOOT_RANGE_HI = 36'h0_1FFF_FFFF;

   typedef enum logic [1:0] {
      SIZE_BYTE  = 2'h0,
      SIZE_HALF  = 2'h1,
      SIZE_WORD  = 2'h2,
      SIZE_DWORD = 2'h3
   } access_size_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACCESS = 2'b01,
      ST_REPLY  = 2'b11
   } ctl_state_t;

   typedef struct packed {
      logic              write;
      logic              local_space;
      logic              external;
      logic [SUB_W-1:0]  master;
      logic [ADDR_W-1:0] addr;
      access_size_t      size;
      logic [63:0]       wdata;
   } ctl_req_t;

endpackage
`default_nettype wire

// ---- core/module_control_space_regs.sv ----
`default_nettype none
module module_control_space_regs
   import ctl_space_pkg::*;
#(
   parameter logic [8*STRING_BYTES-1:0] IDENTITY_STRING = {STRING_BYTES{8'h20}},
   parameter logic [8*STRING_BYTES-1:0] CHANGE_STRING   = {STRING_BYTES{8'h30}},
   parameter logic [PHYS_W-1:0]         BOOT_LO         = BOOT_RANGE_LO,
   parameter logic [PHYS_W-1:0]         BOOT_HI         = BOOT_RANGE_HI
) (
   // clock and bus reset
   input  wire logic                                     ref_clk,
   input  wire logic                                     reset_n,
   // static straps
   input  wire logic                                     big_endian,
   input  wire logic [ADDR_W-1:12]                       module_base,
   // control-space access
   input  wire logic                                     req_valid,
   input  wire ctl_req_t                                 req,
   output logic                                          req_ack,
   output logic [63:0]                                   rsp_rdata,
   // bus parity events
   input  wire logic                                     global_parity_err,
   input  wire logic                                     local_parity_err,
   // interrupt clear from the target processor
   input  wire logic                                     irq_clr_valid,
   input  wire logic                                     irq_clr_local,
   input  wire logic [SUB_W-1:0]                         irq_clr_sub,
   input  wire logic [31:0]                              irq_clr_mask,
   // agent interrupts and control bits
   input  wire logic [SUBPOS_N-1:0][6:0]                 global_agent_irq,
   input  wire logic [SUBPOS_N-1:0][6:0]                 local_agent_irq,
   input  wire logic [SUBPOS_N-1:0][7:0]                 global_agent_ctrl,
   input  wire logic [SUBPOS_N-1:0][7:0]                 local_agent_ctrl,
   input  wire logic [SUBPOS_N-1:0]                      boot_mapped_out,
   // boot window steering
   input  wire logic                                     boot_rd_valid,
   input  wire logic [SUB_W-1:0]                         boot_rd_sub,
   input  wire logic [PHYS_W-1:0]                        boot_rd_addr,
   output logic                                          boot_select,
   output logic                                          memory_select,
   // processor module pins
   input  wire logic [SUBPOS_N*POSITION_FIELD_W-1:0]     position_identity,
   input  wire logic [SUBPOS_N-1:0]                      module_present_n,
   // per-processor outputs
   output logic [SUBPOS_N-1:0]                           selective_cpu_reset,
   output logic [SUBPOS_N-1:0][6:0]                      irq_vector,
   output logic [SUBPOS_N-1:0][PERIPH_W-1:0]             peripheral_irq,
   output logic [SUBPOS_N-1:0][15:0]                     debug_data,
   output logic [SUBPOS_N-1:0]                           led_error,
   output logic [SUBPOS_N-1:0]                           led_busy,
   output logic [SUBPOS_N-1:0]                           led_a,
   output logic [SUBPOS_N-1:0]                           led_b
);

   // lane mask for a narrow access; big endian mirrors lanes
   function automatic logic [7:0] lane_mask(input logic [2:0] a,
                                            input access_size_t sz,
                                            input logic big);
      logic [7:0] base;
      logic [7:0] m;
      logic [7:0] r;
      base = 8'hFF;
      case (sz)
         SIZE_BYTE: base = 8'h01;
         SIZE_HALF: base = 8'h03;
         SIZE_WORD: base = 8'h0F;
         default:   base = 8'hFF;
      endcase
      m = base << a;
      for (int k = 0; k < 8; k++) begin
         r[k] = m[7-k];
      end
      return big ? r : m;
   endfunction

   ctl_state_t state_reg;
   ctl_req_t   req_reg;

   logic [1:0]                     status_reg;
   logic [SUBPOS_N-1:0]            sre_reg;
   logic [SUBPOS_N-1:0][31:0]      irq_global_reg;
   logic [SUBPOS_N-1:0][31:0]      irq_local_reg;
   logic [SUBPOS_N-1:0][15:0]      debug_reg;
   logic [SUBPOS_N-1:0][2:0]       berr_reg;
   logic [63:0]                    rdata_reg;

   logic                           module_hit;
   logic                           mapped;
   logic [3:0]                     req_group;
   logic                           take;
   logic [3:0]                     group;
   logic [SUB_W-1:0]               target;
   logic [STRING_IDX_W-1:0]        str_idx;
   logic [63:0]                    lane_bits;
   logic [7:0]                     lanes;
   logic [63:0]                    wbits;
   logic                           do_write;
   logic                           own_target;
   logic                           wr_status;
   logic                           wr_sre;
   logic                           wr_irq;
   logic                           wr_debug;
   logic                           wr_berr;
   logic [SUBPOS_N*POSITION_FIELD_W-1:0] presence;

   // address comparator: module base and mapped offsets
   assign req_group  = req.addr[GROUP_LSB +: 4];
   assign module_hit = (req.addr[ADDR_W-1:12] == module_base);
   always_comb begin
      mapped = 1'b0;
      if (req.local_space) begin
         mapped = (req_group == OFS_INTERPROC_IRQ[GROUP_LSB +: 4]);
      end else begin
         mapped = (req.addr[11] == 1'b0);
      end
   end
   assign take = (state_reg == ST_IDLE) && req_valid && module_hit && mapped;

   // access sequencer: idle, access, reply
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         req_reg   <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (take) begin
                  state_reg <= ST_ACCESS;
                  req_reg   <= req;
               end
            end
            ST_ACCESS: state_reg <= ST_REPLY;
            ST_REPLY:  state_reg <= ST_IDLE;
            default:   state_reg <= ST_IDLE;
         endcase
      end
   end

   assign req_ack   = (state_reg == ST_REPLY);
   assign rsp_rdata = rdata_reg;

   // decode of the latched access
   assign group      = req_reg.addr[GROUP_LSB +: 4];
   assign target     = req_reg.addr[DWORD_LSB +: SUB_W];
   assign str_idx    = req_reg.addr[DWORD_LSB +: STRING_IDX_W];
   assign own_target = !req_reg.external && (req_reg.master == target);
   assign lanes = lane_mask(req_reg.addr[2:0], req_reg.size, big_endian);
   always_comb begin
      lane_bits = '0;
      for (int k = 0; k < 8; k++) begin
         lane_bits[8*k +: 8] = {8{lanes[k]}};
      end
   end
   assign wbits    = req_reg.wdata & lane_bits;
   assign do_write = (state_reg == ST_ACCESS) && req_reg.write;
   assign wr_status = do_write && !req_reg.local_space
                      && (group == OFS_PARITY_STATUS[GROUP_LSB +: 4]);
   assign wr_sre    = do_write && !req_reg.local_space
                      && (group == OFS_SELECTIVE_RESET[GROUP_LSB +: 4]);
   assign wr_irq    = do_write && !own_target
                      && (group == OFS_INTERPROC_IRQ[GROUP_LSB +: 4]);
   assign wr_debug  = do_write && !req_reg.local_space && !own_target
                      && (group == OFS_DEBUG_MAILBOX[GROUP_LSB +: 4]);
   assign wr_berr   = do_write && !req_reg.local_space
                      && (group == OFS_BUS_ERROR[GROUP_LSB +: 4]);

   // presence fields, empty positions forced to the empty code
   always_comb begin
      presence = position_identity;
      for (int i = 0; i < SUBPOS_N; i++) begin
         if (module_present_n[i]) begin
            presence[POSITION_FIELD_W*i +: POSITION_FIELD_W] = POSITION_EMPTY;
         end
      end
   end

   // read data, right-justified; write-only and reserved bits read zero
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rdata_reg <= '0;
      end else if (state_reg == ST_ACCESS) begin
         rdata_reg <= '0;
         if (!req_reg.write && !req_reg.local_space) begin
            case (group)
               OFS_PARITY_STATUS[GROUP_LSB +: 4]:
                  rdata_reg <= {62'h0, status_reg};
               OFS_IDENTITY_STRING[GROUP_LSB +: 4]:
                  rdata_reg <= {56'h0, IDENTITY_STRING[8*str_idx +: 8]};
               OFS_CHANGE_STRING[GROUP_LSB +: 4]:
                  rdata_reg <= {56'h0, CHANGE_STRING[8*str_idx +: 8]};
               OFS_MODULE_PRESENCE[GROUP_LSB +: 4]:
                  rdata_reg <= {48'h0, presence};
               OFS_BUS_ERROR[GROUP_LSB +: 4]:
                  rdata_reg <= {61'h0, berr_reg[target]};
               default:
                  rdata_reg <= '0;
            endcase
         end
      end
   end

   // parity status: events set, write-one clears, set wins
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         status_reg <= PARITY_STATUS_RST;
      end else begin
         status_reg <= (status_reg & ~(wr_status ? wbits[1:0] : 2'b00))
                       | {local_parity_err, global_parity_err};
      end
   end

   // selective reset per subposition, set by bus reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sre_reg <= {SUBPOS_N{SELECTIVE_RESET_RST}};
      end else if (wr_sre) begin
         sre_reg[target] <= wbits[SELECTIVE_CPU_RESET_BIT];
      end
   end
   assign selective_cpu_reset = sre_reg;

   // interprocessor interrupts: written ones accumulate, processor clears
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_global_reg <= {SUBPOS_N{INTERPROC_IRQ_RST}};
         irq_local_reg  <= {SUBPOS_N{INTERPROC_IRQ_RST}};
      end else begin
         for (int i = 0; i < SUBPOS_N; i++) begin
            logic [31:0] clr_g;
            logic [31:0] clr_l;
            logic [31:0] set_g;
            logic [31:0] set_l;
            clr_g = (irq_clr_valid && !irq_clr_local && irq_clr_sub == SUB_W'(i))
                    ? irq_clr_mask : 32'h0000_0000;
            clr_l = (irq_clr_valid && irq_clr_local && irq_clr_sub == SUB_W'(i))
                    ? irq_clr_mask : 32'h0000_0000;
            set_g = (wr_irq && !req_reg.local_space && target == SUB_W'(i))
                    ? (wbits[31:0] & IRQ_WRITE_MASK) : 32'h0000_0000;
            set_l = (wr_irq && req_reg.local_space && target == SUB_W'(i))
                    ? (wbits[31:0] & IRQ_WRITE_MASK) : 32'h0000_0000;
            irq_global_reg[i] <= (irq_global_reg[i] & ~clr_g) | set_g;
            irq_local_reg[i]  <= (irq_local_reg[i] & ~clr_l) | set_l;
         end
      end
   end

   // debug mailbox data
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         debug_reg <= {SUBPOS_N{DEBUG_MAILBOX_RST}};
      end else if (wr_debug) begin
         debug_reg[target] <= wbits[15:0];
      end
   end
   assign debug_data = debug_reg;

   // bus error flags: parity events and mailbox writes set, write-one clears
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         berr_reg <= {SUBPOS_N{BUS_ERROR_RST}};
      end else begin
         for (int i = 0; i < SUBPOS_N; i++) begin
            logic [2:0] set_b;
            logic [2:0] clr_b;
            set_b = '0;
            set_b[GLOBAL_PARITY_IRQ_BIT] = global_parity_err;
            set_b[LOCAL_PARITY_IRQ_BIT]  = local_parity_err;
            set_b[DEBUG_REQUEST_IRQ_BIT] = wr_debug && (target == SUB_W'(i));
            clr_b = (wr_berr && target == SUB_W'(i)) ? wbits[2:0] : 3'h0;
            berr_reg[i] <= (berr_reg[i] & ~clr_b) | set_b;
         end
      end
   end

   // interrupt vector per processor
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_vector     <= '0;
         peripheral_irq <= '0;
      end else begin
         for (int i = 0; i < SUBPOS_N; i++) begin
            irq_vector[i][VEC_NMI_BIT] <= global_agent_irq[i][VEC_NMI_BIT]
                                          | local_agent_irq[i][VEC_NMI_BIT]
                                          | irq_global_reg[i][VEC_NMI_BIT]
                                          | irq_local_reg[i][VEC_NMI_BIT];
            irq_vector[i][VEC_GENERAL_HI:VEC_GENERAL_LO] <=
               global_agent_irq[i][VEC_GENERAL_HI:VEC_GENERAL_LO]
               | local_agent_irq[i][VEC_GENERAL_HI:VEC_GENERAL_LO]
               | irq_global_reg[i][VEC_GENERAL_HI:VEC_GENERAL_LO]
               | irq_local_reg[i][VEC_GENERAL_HI:VEC_GENERAL_LO];
            irq_vector[i][VEC_TIMER_BIT] <= global_agent_irq[i][VEC_TIMER_BIT];
            irq_vector[i][VEC_ERROR_BIT] <= global_agent_irq[i][VEC_ERROR_BIT]
                                            | local_agent_irq[i][VEC_ERROR_BIT]
                                            | (|berr_reg[i]);
            peripheral_irq[i] <= irq_global_reg[i][PERIPH_LO +: PERIPH_W]
                                 | irq_local_reg[i][PERIPH_LO +: PERIPH_W];
         end
      end
   end

   // front-panel indicators
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         led_error <= '0;
         led_busy  <= '0;
         led_a     <= '0;
         led_b     <= '0;
      end else begin
         for (int i = 0; i < SUBPOS_N; i++) begin
            led_error[i] <= global_agent_ctrl[i][LED_FIRST_BIT];
            led_busy[i]  <= global_agent_ctrl[i][LED_SECOND_BIT];
            led_a[i]     <= local_agent_ctrl[i][LED_FIRST_BIT];
            led_b[i]     <= local_agent_ctrl[i][LED_SECOND_BIT];
         end
      end
   end

   // boot window steering of reads
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         boot_select   <= 1'b0;
         memory_select <= 1'b0;
      end else begin
         logic in_win;
         in_win = (boot_rd_addr >= BOOT_LO) && (boot_rd_addr <= BOOT_HI)
                  && !boot_mapped_out[boot_rd_sub];
         boot_select   <= boot_rd_valid && in_win;
         memory_select <= boot_rd_valid && !in_win;
      end
   end

endmodule
`default_nettype wire

// ---- tb/ctl_space_properties.sv ----
`default_nettype none
module ctl_space_properties
   import ctl_space_pkg::*;
(
   // clock and reset
   input wire logic                     ref_clk,
   input wire logic                     reset_n,
   // access handshake
   input wire logic                     req_valid,
   input wire logic                     req_ack,
   // boot window steering
   input wire logic                     boot_rd_valid,
   input wire logic [SUB_W-1:0]         boot_rd_sub,
   input wire logic [PHYS_W-1:0]        boot_rd_addr,
   input wire logic [SUBPOS_N-1:0]      boot_mapped_out,
   input wire logic                     boot_select,
   input wire logic                     memory_select,
   // agents and per-processor outputs
   input wire logic [SUBPOS_N-1:0][6:0] global_agent_irq,
   input wire logic [SUBPOS_N-1:0][6:0] local_agent_irq,
   input wire logic [SUBPOS_N-1:0][7:0] global_agent_ctrl,
   input wire logic [SUBPOS_N-1:0][6:0] irq_vector,
   input wire logic [SUBPOS_N-1:0]      led_error,
   input wire logic [SUBPOS_N-1:0]      led_busy,
   input wire logic [SUBPOS_N-1:0]      selective_cpu_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // read falls in the flash window and flash is not mapped out
   wire logic hit = boot_rd_addr >= BOOT_RANGE_LO && boot_rd_addr <= BOOT_RANGE_HI
      && !boot_mapped_out[boot_rd_sub];
   chk_ack_after_req: assert property (req_ack |-> $past(req_valid, 2))
      else $error("acknowledge without request");
   chk_ack_one_cycle: assert property (req_ack |=> !req_ack)
      else $error("acknowledge held");
   chk_reset_sets: assert property ($rose(reset_n) |-> selective_cpu_reset == '1)
      else $error("selective reset not set by bus reset");
   chk_boot_flash: assert property (boot_rd_valid && hit |=> boot_select && !memory_select)
      else $error("window read not sent to flash");
   chk_boot_memory: assert property (boot_rd_valid && !hit |=> memory_select && !boot_select)
      else $error("read not sent to memory");
   chk_select_cause: assert property (boot_select || memory_select |-> $past(boot_rd_valid))
      else $error("select without read");
   // per-position vector and indicator relations
   for (genvar i = 0; i < SUBPOS_N; i++) begin : g_pos
      chk_led_follow: assert property ($past(reset_n) |->
         led_error[i] == $past(global_agent_ctrl[i][6]) && led_busy[i] == $past(global_agent_ctrl[i][7]))
         else $error("indicator does not follow control");
      chk_timer_global: assert property ($past(reset_n) |->
         irq_vector[i][1] == $past(global_agent_irq[i][1]))
         else $error("timer bit source wrong");
      chk_general_or: assert property ($past(reset_n) |->
         ($past(global_agent_irq[i][6:2] | local_agent_irq[i][6:2]) & ~irq_vector[i][6:2]) == 5'h0)
         else $error("general bit missing");
      chk_error_or: assert property ($past(reset_n) &&
         $past(global_agent_irq[i][0] | local_agent_irq[i][0]) |-> irq_vector[i][0])
         else $error("error bit missing");
   end
endmodule
bind module_control_space_regs ctl_space_properties chk (.*);
`default_nettype wire

// ---- tb/irq_clear_agent.sv ----
`default_nettype none
module irq_clear_agent
   import ctl_space_pkg::*;
#(parameter int DELAY = 3)
(
   // clock, reset and bench enable
   input wire logic                            ref_clk,
   input wire logic                            reset_n,
   input wire logic                            enable,
   // pending interrupts seen by the processors
   input wire logic [SUBPOS_N-1:0][6:0]        irq_vector,
   input wire logic [SUBPOS_N-1:0][PERIPH_W-1:0] peripheral_irq,
   // clear request towards the bank
   output logic                                irq_clr_valid,
   output logic                                irq_clr_local,
   output logic [SUB_W-1:0]                    irq_clr_sub,
   output logic [31:0]                         irq_clr_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_cnt = 0;
   assign irq_clr_mask = 32'hFFFF_FFFF;
   // scan positions; accept a pending one after a delay and clear its source
   always @(posedge ref_clk) begin
      irq_clr_valid <= 1'b0;
      if (!reset_n || !enable) begin
         wait_cnt <= 0;
         irq_clr_local <= 1'b0;
         irq_clr_sub <= '0;
      end else if (irq_vector[irq_clr_sub][6:2] != 0 || peripheral_irq[irq_clr_sub] != 0) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt == DELAY) begin
            irq_clr_valid <= 1'b1;
            irq_clr_local <= !irq_clr_local;
            wait_cnt <= 0;
         end
      end else irq_clr_sub <= irq_clr_sub + 1'b1;
   end
endmodule
`default_nettype wire

// ---- tb/module_control_space_regs_tb.sv ----
`default_nettype none
module module_control_space_regs_tb;
   import ctl_space_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, reset_n = 0, req_valid = 0, clr_en = 0, boot_rd_valid = 0;
   logic global_parity_err = 0, local_parity_err = 0;
   logic req_ack, boot_select, memory_select, irq_clr_valid, irq_clr_local;
   ctl_req_t req = '0;
   logic [SUBPOS_N-1:0][6:0] global_agent_irq = '0, local_agent_irq = '0, irq_vector;
   logic [SUBPOS_N-1:0][7:0] global_agent_ctrl = '0, local_agent_ctrl = '0;
   logic [SUBPOS_N-1:0] boot_mapped_out = '0, module_present_n = '0;
   logic [SUBPOS_N-1:0] selective_cpu_reset, led_error, led_busy, led_a, led_b;
   logic [SUB_W-1:0] boot_rd_sub = '0, irq_clr_sub;
   logic [PHYS_W-1:0] boot_rd_addr = '0;
   logic [15:0] position_identity = '0, lfsr = 16'hFFAF, p;
   logic [31:0] irq_clr_mask, d;
   logic [63:0] rsp_rdata;
   logic [SUBPOS_N-1:0][PERIPH_W-1:0] peripheral_irq;
   logic [SUBPOS_N-1:0][15:0] debug_data;
   logic [63:0] exp_q[$];
   int num_errors = 0, comparisons = 0;
   module_control_space_regs DUT (.big_endian(1'b0), .module_base(4'h3), .*);
   irq_clear_agent partner (.enable(clr_en), .*);
   always #20 ref_clk = ~ref_clk;
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // scoreboard: each acknowledge retires the oldest expected value
   always @(posedge ref_clk) if (req_ack === 1'b1) check(rsp_rdata, exp_q.pop_front());
   // one access held until acknowledged or for 8 cycles; tk = 0 expects it to be ignored
   task automatic acc(input logic w, l, x, input logic [1:0] m, input logic [15:0] a,
                      input access_size_t sz, input logic [63:0] wd, ex, input logic tk);
      int n;
      @(posedge ref_clk);
      req <= {w, l, x, m, a, sz, wd};
      req_valid <= 1'b1;
      if (tk) exp_q.push_back(ex);
      for (n = 0; n < 8; n++) begin
         @(posedge ref_clk);
         if (req_ack === 1'b1) break;
      end
      req_valid <= 1'b0;
      check(n < 8, tk);
      if (tk && n == 8) test_done();
   endtask
   task automatic rd(input logic [15:0] a, input logic [63:0] ex);
      acc(0, 0, 1, 0, a, SIZE_DWORD, 0, ex, 1);
   endtask
   task automatic wr(input logic [15:0] a, input logic [63:0] wd);
      acc(1, 0, 1, 0, a, SIZE_DWORD, wd, 0, 1);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      check(selective_cpu_reset, 4'hF);
      rd(16'h3000, 0);
      rd(16'h3710, 0);
      @(posedge ref_clk) global_parity_err <= 1;
      @(posedge ref_clk) global_parity_err <= 0;
      rd(16'h3710, 1);
      check(irq_vector[2][0], 1);
      @(posedge ref_clk) local_parity_err <= 1;
      @(posedge ref_clk) local_parity_err <= 0;
      rd(16'h3000, 3);
      wr(16'h3000, 1);
      rd(16'h3000, 2);
      for (int s = 0; s < 4; s++) wr(16'h3700 | 16'(s * 8), 7);
      rd(16'h3710, 0);
      check(irq_vector[2][0], 0);
      wr(16'h3108, 0);
      check(selective_cpu_reset, 4'hD);
      rd(16'h3108, 0);
      $display("test status and reset done");
      for (int s = 0; s < 32; s++) begin
         rd(16'h3200 + 16'(s * 8), 64'h20);
         rd(16'h3300 + 16'(s * 8), 64'h30);
      end
      d = {rnd(), 16'h0044};
      acc(1, 0, 0, 0, 16'h3408, SIZE_DWORD, d, 0, 1);
      @(posedge ref_clk);
      check(irq_vector[1][6:2], 5'h11);
      p = rnd();
      acc(1, 0, 0, 0, 16'h3408, SIZE_DWORD, {p, 16'h0}, 0, 1);
      @(posedge ref_clk);
      check(peripheral_irq[1], d[31:16] | p);
      acc(1, 0, 0, 1, 16'h3408, SIZE_DWORD, 64'hFFFF_FFFF, 0, 1);
      check(irq_vector[1][6:2], 5'h11);
      check(peripheral_irq[1], d[31:16] | p);
      acc(1, 1, 1, 0, 16'h3408, SIZE_DWORD, 64'h8000_0000, 0, 1);
      @(posedge ref_clk);
      check(peripheral_irq[1][15], 1);
      rd(16'h3408, 0);
      clr_en <= 1'b1;
      for (int s = 0; s <= 60; s++) begin
         @(posedge ref_clk);
         if (peripheral_irq[1] === 0 && irq_vector[1][6:2] === 0) break;
         check(s < 60, 1);
         if (s == 60) test_done();
      end
      clr_en <= 1'b0;
      acc(1, 0, 0, 0, 16'h3511, SIZE_BYTE, 64'hFFFF, 0, 1);
      check(debug_data[2], 16'hFF00);
      rd(16'h3710, 4);
      check(irq_vector[2][0], 1);
      acc(1, 0, 0, 2, 16'h3510, SIZE_DWORD, 64'h1234, 0, 1);
      check(debug_data[2], 16'hFF00);
      wr(16'h3710, 4);
      $display("test interrupts and mailbox done");
      p = rnd();
      position_identity <= p;
      module_present_n <= 4'h8;
      rd(16'h3600, {4'hF, p[11:0]});
      acc(0, 0, 1, 0, 16'h3800, SIZE_DWORD, 0, 0, 0);
      acc(0, 1, 1, 0, 16'h3000, SIZE_DWORD, 0, 0, 0);
      acc(0, 0, 1, 0, 16'h5000, SIZE_DWORD, 0, 0, 0);
      for (int s = 0; s < 24; s++) begin
         @(posedge ref_clk);
         global_agent_ctrl <= {rnd(), rnd()};
         local_agent_ctrl <= {rnd(), rnd()};
         global_agent_irq <= {rnd(), rnd()};
         local_agent_irq <= {rnd(), rnd()};
         boot_mapped_out <= rnd();
         boot_rd_valid <= 1'b1;
         boot_rd_sub <= rnd();
         boot_rd_addr <= s[0] ? (s[1] ? BOOT_RANGE_HI + 1 : BOOT_RANGE_HI)
                              : (s[1] ? BOOT_RANGE_LO - 1 : BOOT_RANGE_LO);
      end
      @(posedge ref_clk);
      boot_rd_valid <= 1'b0;
      global_agent_irq <= '0;
      local_agent_irq <= {4{7'h02}};
      repeat (2) @(posedge ref_clk);
      check(irq_vector[0][1], 0);
      for (int i = 0; i < 4; i++) check(led_a[i], local_agent_ctrl[i][6]);
      check(led_b, {local_agent_ctrl[3][7], local_agent_ctrl[2][7], local_agent_ctrl[1][7], local_agent_ctrl[0][7]});
      $display("test presence, agents and boot done");
      test_done();
   end
endmodule
`default_nettype wire
